/* hdl/ext_frame_sync_align.sv */
// Functional notes
// - Enable bit low disables external frame sync regardless of anything.
// - Manual mode uses pin A whenever locked; pins B and C ignored.
// - Auto mode uses pin A only when locked to the source input.
// - Source field 11XX selects automatic three-pin mode.
// - Association field maps pins A and B onto inputs three to six.
// - Pin C always belongs to input nine in three-pin mode.
// - Three-pin mode enables the pin tied to the locked input.
// - In three-pin mode auto bit clears enable on reference change.
// - Locked only when the operating state reads 100.
// - Disabled frame sync uses no pin; generators keep free-running.
// - Sync pin is first sampled on the reference rising edge.
// - Per-pin phase field shifts sampling half early to one late.
// - Resample at 6.48MHz when the rate bit is clear.
// - Rate bit set with 19.44MHz reference resamples at 19.44MHz.
// - Qualified after 64 consecutive falling edges on 2kHz boundaries.
// - One missing edge at the boundary disqualifies at once.
// - Alignment only while locked, enabled and qualified.
// - Frame pulses share one generator; other outputs use a second.
// - Without enable or qualification both generators free-run.
// - Enabled and qualified sync aligns the frame-pulse generator.
// - Decouple low also aligns the main generator to frame pulses.
// - Decouple high leaves the main generator free-running.
// - Only the falling edge of the sync signal counts.
// - Disqualification disconnects both generators immediately.
`timescale 1ns/1ps
`default_nettype none
module ext_frame_sync_align
   import fs_align_pkg::*;
#(
   parameter int PERIOD_LOW_P = PERIOD_LOW,
   parameter int PERIOD_HIGH_P = PERIOD_HIGH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable_wr,
   input wire logic enable_wr_data,
   input wire logic framesync_auto_bit,
   input wire logic [3:0] source_field,
   input wire logic [2:0] pin_association_field,
   input wire logic [3:0] selected_reference,
   input wire logic [2:0] primary_dpll_op_state,
   input wire logic [1:0] sample_phase_adjust_a,
   input wire logic [1:0] sample_phase_adjust_b,
   input wire logic [1:0] sample_phase_adjust_c,
   input wire logic resample_rate_sel,
   input wire logic ref_is_19m44,
   input wire logic main_align_decouple,
   input wire logic sync_pin_a,
   input wire logic sync_pin_b,
   input wire logic sync_pin_c,
   input wire logic ref_rise_tick,
   input wire logic ref_fall_tick,
   input wire logic resample_tick_low,
   input wire logic resample_tick_high,
   output logic ext_framesync_enable,
   output logic framesync_active,
   output logic [1:0] active_pin,
   output logic sync_qualified,
   output logic frame_pulse_out_8k,
   output logic frame_pulse_out_2k,
   output logic main_align_2k
);
   localparam logic [CNT_W-1:0] LAST_LOW = CNT_W'(PERIOD_LOW_P - 1);
   localparam logic [CNT_W-1:0] LAST_HIGH = CNT_W'(PERIOD_HIGH_P - 1);
   localparam logic [QUAL_W-1:0] QUAL_FULL = QUAL_W'(QUAL_EDGES);

   // Phase-selected capture helper used for every sync pin.
   function automatic logic take_rise(input logic [1:0] code);
      take_rise = (code != PH_LATE_HALF);
   endfunction : take_rise

   fs_sel_if sel ();

   logic enable_reg;
   logic [3:0] last_ref_reg;
   logic fall_cap_reg;
   logic rise_cap_reg;
   logic sampled_reg;
   logic resampled_reg;
   logic resampled_prev_reg;
   logic [CNT_W-1:0] phase_reg;
   logic [CNT_W-1:0] phase_next;
   logic [QUAL_W-1:0] good_reg;
   logic [QUAL_W-1:0] good_next;
   logic qual_reg;
   logic qual_next;
   sync_pin_t pin_reg;
   logic active_reg;
   logic fp8_reg;
   logic fp2_reg;
   logic main_reg;
   logic [CNT_W-1:0] fp_count;
   logic [CNT_W-1:0] main_count;
   logic fp_wrap;
   logic main_wrap;

   // Lock test on the primary DPLL operating state.
   wire locked = (primary_dpll_op_state == LOCK_STATE);

   fs_source_sel u_sel (
      .enable(enable_reg),
      .auto_bit(framesync_auto_bit),
      .source_field(source_field),
      .assoc_field(pin_association_field),
      .sel_ref(selected_reference),
      .locked(locked),
      .sel(sel.producer)
   );

   // Automatic clear of the enable bit on a reference change.
   wire ref_changed = (selected_reference != last_ref_reg);
   wire auto_clear = sel.three_pin && framesync_auto_bit
                     && ref_changed;
   wire enable_next = enable_wr ? enable_wr_data :
                      auto_clear ? 1'b0 : enable_reg;

   // Enable bit and reference history; a software write wins.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enable_reg <= 1'b0;
         last_ref_reg <= 4'h0;
      end else begin
         enable_reg <= enable_next;
         last_ref_reg <= selected_reference;
      end
   end

   // Pick the pin and its phase code; an idle pin reads high.
   wire pin_level = (sel.pin_sel == PIN_A) ? sync_pin_a :
                    (sel.pin_sel == PIN_B) ? sync_pin_b :
                    (sel.pin_sel == PIN_C) ? sync_pin_c : 1'b1;
   wire [1:0] phase_code = (sel.pin_sel == PIN_B) ? sample_phase_adjust_b :
                           (sel.pin_sel == PIN_C) ? sample_phase_adjust_c :
                           sample_phase_adjust_a;
   wire rise_take = ref_rise_tick && take_rise(phase_code);
   wire fall_take = ref_fall_tick && !take_rise(phase_code);
   wire sample_val = (phase_code == PH_EARLY_HALF) ? fall_cap_reg :
                     (phase_code == PH_LATE_ONE) ? rise_cap_reg :
                     pin_level;

   // First sampling on reference edges.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fall_cap_reg <= 1'b1;
         rise_cap_reg <= 1'b1;
         sampled_reg <= 1'b1;
      end else begin
         if (ref_fall_tick) begin
            fall_cap_reg <= pin_level;
         end
         if (ref_rise_tick) begin
            rise_cap_reg <= pin_level;
         end
         if (rise_take || fall_take) begin
            sampled_reg <= sample_val;
         end
      end
   end

   // Resampling rate and period selection.
   wire use_high = resample_rate_sel && ref_is_19m44;
   wire rs_tick = use_high ? resample_tick_high : resample_tick_low;
   wire [CNT_W-1:0] period_last = use_high ? LAST_HIGH : LAST_LOW;

   // Resampling register pair for edge detection.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         resampled_reg <= 1'b1;
         resampled_prev_reg <= 1'b1;
      end else if (rs_tick) begin
         resampled_reg <= sampled_reg;
         resampled_prev_reg <= resampled_reg;
      end
   end

   // Falling edge only; a rising edge is ignored.
   wire fall_edge = rs_tick && resampled_prev_reg
                    && !resampled_reg;
   wire at_bound = (phase_reg >= period_last);
   wire good_edge = fall_edge && at_bound;
   wire bad_edge = fall_edge && !at_bound;
   wire missing = rs_tick && at_bound && !fall_edge;
   wire pin_changed = (sel.pin_sel != pin_reg);
   wire qual_reset = !sel.fs_active || pin_changed;

   // Qualification: count good edges, drop on any miss.
   assign phase_next = (!rs_tick) ? phase_reg :
                       (fall_edge || at_bound) ? '0 :
                       phase_reg + 1'b1;
   assign good_next = qual_reset ? '0 :
                      (bad_edge || missing) ? '0 :
                      (good_edge && good_reg != QUAL_FULL) ?
                      good_reg + 1'b1 : good_reg;
   assign qual_next = !qual_reset && !bad_edge && !missing
                      && (good_next == QUAL_FULL);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_reg <= '0;
         good_reg <= '0;
         qual_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         good_reg <= good_next;
         qual_reg <= qual_next;
      end
   end

   // Alignment gate; the live edge check keeps a bad edge from loading.
   wire align_ok = locked && sel.fs_active && qual_reg;
   wire fp_load = align_ok && good_edge;
   wire main_load = align_ok && !main_align_decouple
                    && (fp_load || fp_wrap);

   fs_align_gen u_fp_gen (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(rs_tick),
      .period_last(period_last),
      .load(fp_load),
      .count(fp_count),
      .wrap(fp_wrap)
   );

   fs_align_gen u_main_gen (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(rs_tick),
      .period_last(period_last),
      .load(main_load),
      .count(main_count),
      .wrap(main_wrap)
   );

   // Output clocks fall at each generator boundary.
   wire [CNT_W-1:0] half_2k = period_last >> 1;
   wire [CNT_W-1:0] quarter = CNT_W'((32'(period_last) + 1) / SUB_DIV);
   wire [CNT_W-1:0] sub_pos = CNT_W'(32'(fp_count) % 32'(quarter));
   wire fp2_w = (fp_count > half_2k);
   wire fp8_w = (sub_pos >= (quarter >> 1));
   wire main_w = (main_count > half_2k);

   // Registered outputs.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fp2_reg <= 1'b0;
         fp8_reg <= 1'b0;
         main_reg <= 1'b0;
         pin_reg <= PIN_NONE;
         active_reg <= 1'b0;
      end else begin
         fp2_reg <= fp2_w;
         fp8_reg <= fp8_w;
         main_reg <= main_w;
         pin_reg <= sel.pin_sel;
         active_reg <= sel.fs_active;
      end
   end

   assign ext_framesync_enable = enable_reg;
   assign framesync_active = active_reg;
   assign active_pin = pin_reg;
   assign sync_qualified = qual_reg;
   assign frame_pulse_out_8k = fp8_reg;
   assign frame_pulse_out_2k = fp2_reg;
   assign main_align_2k = main_reg;

   // Checks on the selection, enable and lock paths.
   off_disables_a: assert property (@(posedge clk) disable iff (sys_rst)
      !enable_reg |-> sel.pin_sel == PIN_NONE)
      else $error("frame sync active with enable clear");
   manual_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
      enable_reg && locked && !sel.three_pin && !framesync_auto_bit
      |-> sel.pin_sel == PIN_A)
      else $error("manual mode did not pick pin A");
   auto_source_a: assert property (@(posedge clk) disable iff (sys_rst)
      !sel.three_pin && framesync_auto_bit
      && selected_reference != source_field
      |-> !sel.fs_active)
      else $error("auto mode active on wrong reference");
   third_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
      enable_reg && locked && sel.three_pin
      && selected_reference == REF_IN_NINE
      |-> sel.pin_sel == PIN_C)
      else $error("input nine did not select pin C");
   auto_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      sel.three_pin && framesync_auto_bit && ref_changed && !enable_wr
      |=> !enable_reg)
      else $error("enable not cleared on reference change");
   lock_only_a: assert property (@(posedge clk) disable iff (sys_rst)
      !locked |-> !sel.fs_active)
      else $error("frame sync active while unlocked");

   // Sampling phase checks; the sample lands one clock after the tick.
   rise_sample_a: assert property (@(posedge clk) disable iff (sys_rst)
      ref_rise_tick && phase_code == PH_NOMINAL
      |=> sampled_reg == $past(pin_level))
      else $error("nominal phase did not sample on the rising edge");
   phase_late_a: assert property (@(posedge clk) disable iff (sys_rst)
      rise_take && phase_code == PH_LATE_ONE
      |=> sampled_reg == $past(rise_cap_reg))
      else $error("late phase code did not use the previous rising sample");

   // Qualification and alignment checks.
   qual_count_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(qual_reg) |-> $past(good_reg) == QUAL_FULL - 1'b1)
      else $error("qualified without the full edge count");
   qual_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
      good_edge && !qual_reset && good_reg == QUAL_FULL - 1'b1
      |=> qual_reg)
      else $error("last good edge did not qualify the sync");
   miss_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
      missing |=> !qual_reg && good_reg == '0)
      else $error("missing edge did not disqualify");
   no_align_a: assert property (@(posedge clk) disable iff (sys_rst)
      !qual_reg |-> !fp_load && !main_load)
      else $error("generator loaded while unqualified");
   decouple_a: assert property (@(posedge clk) disable iff (sys_rst)
      main_align_decouple |-> !main_load)
      else $error("main generator loaded while decoupled");
   main_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
      fp_load && !main_align_decouple |=> main_count == fp_count)
      else $error("main generator not restarted with the frame generator");
   fp_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
      fp_load |=> fp_count == '0)
      else $error("frame generator not restarted by sync");
   rise_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
      rs_tick && !resampled_prev_reg && resampled_reg && !at_bound
      && !qual_reset |=> good_reg == $past(good_reg))
      else $error("rising edge disturbed the qualification count");

   // Main scenarios: qualify, align, follow, auto-clear, decoupled wrap.
   qualified_c: cover property (@(posedge clk) disable iff (sys_rst)
      $rose(qual_reg));
   fp_aligned_c: cover property (@(posedge clk) disable iff (sys_rst)
      fp_load);
   main_aligned_c: cover property (@(posedge clk) disable iff (sys_rst)
      main_load && !fp_load);
   auto_clear_c: cover property (@(posedge clk) disable iff (sys_rst)
      auto_clear && enable_reg);
   main_free_c: cover property (@(posedge clk) disable iff (sys_rst)
      main_wrap && main_align_decouple);
endmodule : ext_frame_sync_align
`default_nettype wire

/* hdl/fs_align_pkg.sv */
package fs_align_pkg;
   // Operating state code that means the primary DPLL is locked.
   localparam logic [2:0] LOCK_STATE = 3'h4;
   // Reference input numbers as seen on the selected reference field.
   localparam logic [3:0] REF_IN_THREE = 4'h3;
   localparam logic [3:0] REF_IN_FOUR = 4'h4;
   localparam logic [3:0] REF_IN_FIVE = 4'h5;
   localparam logic [3:0] REF_IN_SIX = 4'h6;
   localparam logic [3:0] REF_IN_NINE = 4'h9;
   // Top two bits of the source field that select three-pin mode.
   localparam logic [1:0] SRC_THREE_PIN = 2'h3;
   // Bit positions inside the pin association field.
   localparam int ASSOC_SPLIT_BIT = 2;
   localparam int ASSOC_HIGH_BIT = 0;
   // Sync pin selection codes.
   typedef enum logic [1:0] {PIN_NONE, PIN_A, PIN_B, PIN_C} sync_pin_t;
   // Sampling phase codes.
   localparam logic [1:0] PH_NOMINAL = 2'h0;
   localparam logic [1:0] PH_EARLY_HALF = 2'h1;
   localparam logic [1:0] PH_LATE_ONE = 2'h2;
   localparam logic [1:0] PH_LATE_HALF = 2'h3;
   // Resampling rates and frame rate, all in kHz.
   localparam int RATE_LOW_KHZ = 6480;
   localparam int RATE_HIGH_KHZ = 19440;
   localparam int FRAME_KHZ = 2;
   localparam int PERIOD_LOW = RATE_LOW_KHZ / FRAME_KHZ;
   localparam int PERIOD_HIGH = RATE_HIGH_KHZ / FRAME_KHZ;
   // Counter width for one 2kHz period of resample ticks.
   localparam int CNT_W = 14;
   // Consecutive good edges needed before the sync is trusted.
   localparam int QUAL_EDGES = 64;
   localparam int QUAL_W = 7;
   // The 8kHz pulse divides the 2kHz period by this amount.
   localparam int SUB_DIV = 4;
endpackage : fs_align_pkg

/* hdl/fs_sel_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries the frame-sync source decision from the selector to the top.
interface fs_sel_if;
   import fs_align_pkg::*;
   logic fs_active;
   sync_pin_t pin_sel;
   logic three_pin;
   modport producer (output fs_active, output pin_sel, output three_pin);
   modport consumer (input fs_active, input pin_sel, input three_pin);
endinterface : fs_sel_if
`default_nettype wire

/* hdl/fs_source_sel.sv */
`timescale 1ns/1ps
`default_nettype none
module fs_source_sel
   import fs_align_pkg::*;
(
   input wire logic enable,
   input wire logic auto_bit,
   input wire logic [3:0] source_field,
   input wire logic [2:0] assoc_field,
   input wire logic [3:0] sel_ref,
   input wire logic locked,
   fs_sel_if.producer sel
);
   // Mode decode from the enable, source and auto settings.
   wire three_pin_w = (source_field[3:2] == SRC_THREE_PIN);
   wire manual_w = enable && locked && !three_pin_w && !auto_bit;
   wire auto_w = enable && locked && !three_pin_w && auto_bit
                 && (sel_ref == source_field);
   // Association of pins with reference inputs in three-pin mode.
   wire split_w = assoc_field[ASSOC_SPLIT_BIT];
   wire hi_w = assoc_field[ASSOC_HIGH_BIT];
   wire a_three = !split_w || !hi_w;
   wire a_five = !split_w || hi_w;
   wire a_hit = (a_three && sel_ref == REF_IN_THREE)
                || (a_five && sel_ref == REF_IN_FIVE);
   wire b_hit = (a_three && sel_ref == REF_IN_FOUR)
                || (a_five && sel_ref == REF_IN_SIX);
   wire c_hit = (sel_ref == REF_IN_NINE);
   wire tp_en = enable && locked && three_pin_w;
   // Final selection; everything off when the enable bit is clear.
   assign sel.three_pin = three_pin_w;
   assign sel.pin_sel = !enable ? PIN_NONE :
                        (manual_w || auto_w) ? PIN_A :
                        (tp_en && a_hit) ? PIN_A :
                        (tp_en && b_hit) ? PIN_B :
                        (tp_en && c_hit) ? PIN_C : PIN_NONE;
   assign sel.fs_active = (sel.pin_sel != PIN_NONE);
endmodule : fs_source_sel
`default_nettype wire

/* hdl/fs_align_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module fs_align_gen
   import fs_align_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic [CNT_W-1:0] period_last,
   input wire logic load,
   output logic [CNT_W-1:0] count,
   output logic wrap
);
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   // Free-run over one 2kHz period, or restart at zero on a load.
   assign wrap = tick && (count_reg >= period_last);
   assign count_next = !tick ? count_reg :
                       (load || wrap) ? '0 : count_reg + 1'b1;
   assign count = count_reg;
   // Counter register.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end
endmodule : fs_align_gen
`default_nettype wire

/* sim/sync_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_card_model #(
   parameter int FRAME = 96
) (
   input wire logic clk,
   input wire logic [6:0] shift,
   input wire logic drop,
   output logic ref_rise_tick,
   output logic ref_fall_tick,
   output logic resample_tick_low,
   output logic resample_tick_high,
   output logic sync_pin_a,
   output logic sync_pin_b,
   output logic sync_pin_c,
   output int phase
);
   int cyc = 0;
   int ph;
   logic toggle_reg = 1'b0;
   // Card timebase advances on the falling clock edge, like all stimulus.
   always @(negedge clk) begin
      cyc <= (cyc == FRAME - 1) ? 0 : cyc + 1;
      toggle_reg <= ~toggle_reg;
   end
   // Reference and resample ticks; one frame is 16 low or 48 high ticks.
   assign ref_rise_tick = (cyc % 2 == 0);
   assign ref_fall_tick = (cyc % 2 == 1);
   assign resample_tick_low = (cyc % 6 == 0);
   assign resample_tick_high = (cyc % 2 == 0);
   // Sync falls at frame start plus shift; drop hides the edge.
   assign ph = (cyc + FRAME - int'(shift)) % FRAME;
   assign sync_pin_a = drop ? 1'b1 : (ph >= FRAME / 2);
   // Pin B chatters so that a wrong selection never qualifies.
   assign sync_pin_b = toggle_reg;
   assign sync_pin_c = 1'b1;
   assign phase = cyc;
endmodule : sync_card_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fs_align_pkg::*;
   logic clk, sys_rst, wr, wr_d, auto_bit, rate_sel, ref_19, decouple;
   logic [3:0] src, sel_ref;
   logic [2:0] assoc, op_state;
   logic [1:0] ph_a, ph_b, ph_c, act_pin;
   logic [6:0] shift;
   logic drop, rr, rf, tl, th, pa, pb, pc;
   logic fs_en, fs_act, qual, fp8k, fp2k, main2k;
   int phase, n_mismatch, n_compared, p0, p1, pm;
   ext_frame_sync_align #(.PERIOD_LOW_P(16), .PERIOD_HIGH_P(48)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .enable_wr(wr), .enable_wr_data(wr_d),
      .framesync_auto_bit(auto_bit), .source_field(src),
      .pin_association_field(assoc), .selected_reference(sel_ref),
      .primary_dpll_op_state(op_state), .sample_phase_adjust_a(ph_a),
      .sample_phase_adjust_b(ph_b), .sample_phase_adjust_c(ph_c),
      .resample_rate_sel(rate_sel), .ref_is_19m44(ref_19),
      .main_align_decouple(decouple), .sync_pin_a(pa), .sync_pin_b(pb),
      .sync_pin_c(pc), .ref_rise_tick(rr), .ref_fall_tick(rf),
      .resample_tick_low(tl), .resample_tick_high(th),
      .ext_framesync_enable(fs_en), .framesync_active(fs_act),
      .active_pin(act_pin), .sync_qualified(qual),
      .frame_pulse_out_8k(fp8k), .frame_pulse_out_2k(fp2k),
      .main_align_2k(main2k));
   sync_card_model #(.FRAME(96)) u_card (
      .clk(clk), .shift(shift), .drop(drop), .ref_rise_tick(rr),
      .ref_fall_tick(rf), .resample_tick_low(tl), .resample_tick_high(th),
      .sync_pin_a(pa), .sync_pin_b(pb), .sync_pin_c(pc), .phase(phase));
   // Free-running 125 MHz clock.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic stop_test();
      if (n_mismatch == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Writes the enable bit with a one-cycle strobe.
   task automatic wr_en(input logic v);
      @(negedge clk);
      wr = 1'b1;
      wr_d = v;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_en
   // Applies a mode, writes the enable bit, then checks the chosen pin.
   task automatic sel(input logic en, input logic au, input logic [3:0] s,
         input logic [2:0] a, input logic [3:0] r, input logic [2:0] st,
         input logic [1:0] exp);
      @(negedge clk);
      auto_bit = au;
      src = s;
      assoc = a;
      sel_ref = r;
      op_state = st;
      wr_en(en);
      repeat (3) @(negedge clk);
      check(act_pin, exp);
      check(fs_act, exp != 2'h0);
   endtask : sel
   // Bounded wait for the qualification flag to reach a level.
   task automatic wait_q(input logic v, input int lim);
      int i;
      for (i = 0; i < lim && qual !== v; i++)
         @(negedge clk);
      check(qual, v);
   endtask : wait_q
   // Waits for a falling edge of one clock output, returns card phase.
   task automatic fall_ph(input int which, output int ph);
      logic prev, cur;
      int i;
      prev = 1'b0;
      for (i = 0; i < 300; i++) begin
         @(posedge clk);
         #1;
         cur = (which == 0) ? fp2k : (which == 1) ? main2k : fp8k;
         if (prev === 1'b1 && cur === 1'b0)
            break;
         prev = cur;
      end
      ph = phase;
      check(i < 300, 1);
   endtask : fall_ph
   // Watchdog sized well above four qualification runs.
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      stop_test();
   end
   // Main sequence of scenarios.
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      {sys_rst, wr, wr_d, auto_bit, rate_sel, ref_19, decouple, drop} = 8'hFF;
      {wr, wr_d, auto_bit, rate_sel, ref_19, decouple, drop} = 7'h00;
      {src, sel_ref, assoc, op_state} = 14'h0000;
      {ph_a, ph_b, ph_c} = 6'h00;
      shift = 7'h00;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      check({fs_en, fs_act, act_pin, qual, fp8k, fp2k, main2k}, 0);
      sel(0, 0, 4'h1, 3'h0, 4'h7, LOCK_STATE, 2'h0);
      sel(1, 0, 4'h1, 3'h0, 4'h7, LOCK_STATE, 2'h1);
      sel(1, 0, 4'h1, 3'h0, 4'h7, 3'h5, 2'h0);
      sel(1, 1, 4'h3, 3'h0, REF_IN_THREE, LOCK_STATE, 2'h1);
      sel(1, 1, 4'h3, 3'h0, REF_IN_FOUR, LOCK_STATE, 2'h0);
      sel(1, 1, 4'hD, 3'h0, REF_IN_FIVE, LOCK_STATE, 2'h1);
      sel(1, 0, 4'hC, 3'h0, REF_IN_THREE, LOCK_STATE, 2'h1);
      sel(1, 0, 4'hC, 3'h3, REF_IN_SIX, LOCK_STATE, 2'h2);
      sel(1, 0, 4'hC, 3'h0, REF_IN_FOUR, LOCK_STATE, 2'h2);
      sel(1, 0, 4'hE, 3'h4, REF_IN_THREE, LOCK_STATE, 2'h1);
      sel(1, 0, 4'hE, 3'h6, REF_IN_FOUR, LOCK_STATE, 2'h2);
      sel(1, 0, 4'hE, 3'h4, REF_IN_FIVE, LOCK_STATE, 2'h0);
      sel(1, 0, 4'hF, 3'h5, REF_IN_FIVE, LOCK_STATE, 2'h1);
      sel(1, 0, 4'hF, 3'h7, REF_IN_SIX, LOCK_STATE, 2'h2);
      sel(1, 0, 4'hF, 3'h5, REF_IN_THREE, LOCK_STATE, 2'h0);
      sel(1, 0, 4'hC, 3'h5, REF_IN_NINE, LOCK_STATE, 2'h3);
      sel(1, 0, 4'hC, 3'h0, 4'h7, LOCK_STATE, 2'h0);
      sel(1, 0, 4'hC, 3'h0, REF_IN_NINE, 3'h2, 2'h0);
      sel(1, 1, 4'hC, 3'h0, REF_IN_THREE, LOCK_STATE, 2'h1);
      @(negedge clk);
      sel_ref = REF_IN_FOUR;
      repeat (3) @(negedge clk);
      check(fs_en, 1'b0);
      check(act_pin, 2'h0);
      sel(1, 0, 4'hC, 3'h0, REF_IN_THREE, LOCK_STATE, 2'h1);
      @(negedge clk);
      sel_ref = REF_IN_FIVE;
      repeat (3) @(negedge clk);
      check(fs_en, 1'b1);
      sel(1, 0, 4'h1, 3'h0, 4'h7, LOCK_STATE, 2'h1);
      repeat (62 * 96) @(negedge clk);
      check(qual, 1'b0);
      wait_q(1'b1, 10 * 96);
      // The first fall may still be the free-running one; skip it.
      fall_ph(0, p0);
      fall_ph(0, p0);
      fall_ph(0, p1);
      check(p1, p0);
      fall_ph(1, pm);
      check(pm, p0);
      fall_ph(2, p1);
      fall_ph(2, pm);
      check((pm - p1 + 96) % 96, 24);
      @(negedge clk);
      drop = 1'b1;
      wait_q(1'b0, 2 * 96);
      @(negedge clk);
      drop = 1'b0;
      fall_ph(0, p1);
      check(p1, p0);
      wait_q(1'b1, 70 * 96);
      @(negedge clk);
      decouple = 1'b1;
      shift = 7'd24;
      wait_q(1'b0, 2 * 96);
      fall_ph(0, p1);
      check(p1, p0);
      wait_q(1'b1, 70 * 96);
      fall_ph(0, p1);
      fall_ph(0, p1);
      check(p1, (p0 + 24) % 96);
      fall_ph(1, pm);
      check(pm, p0);
      @(negedge clk);
      decouple = 1'b0;
      fall_ph(0, p1);
      fall_ph(1, pm);
      fall_ph(1, pm);
      check(pm, (p0 + 24) % 96);
      wr_en(1'b0);
      repeat (3) @(negedge clk);
      check({fs_act, qual}, 2'h0);
      fall_ph(0, p1);
      check(p1, (p0 + 24) % 96);
      @(negedge clk);
      rate_sel = 1'b1;
      ref_19 = 1'b1;
      ph_a = PH_LATE_ONE;
      wr_en(1'b1);
      wait_q(1'b1, 72 * 96);
      fall_ph(0, p1);
      fall_ph(0, p1);
      // Detection now takes two 2-cycle ticks, the late code two more cycles.
      check(p1, (p0 + 24 + 2 - 2 * (6 - 2)) % 96);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
